/* design/bytecode_accel_consts.vh */
/*
 header of constants for the bytecode acceleration configuration registers.
 assumes inclusion by bare name from the design files.
*/
`ifndef BYTECODE_ACCEL_CONSTS_VH
`define BYTECODE_ACCEL_CONSTS_VH

// coprocessor access selectors
`define CP_NUM 4'he
`define CP_OPC1 3'h7
`define CP_CRM 4'h0
`define CP_OPC2 3'h0
`define CRN_IDENTITY 4'h0
`define CRN_OS_CONTROL 4'h1
`define CRN_MAIN_CONFIG 4'h2
`define CRN_LAYOUT_PARAMS 4'h3
`define CRN_OPCODE_TRANS 4'h4

// main configuration fields
`define MC_ARRAY_SW_BIT 31
`define MC_FLOAT_HW_BIT 30
`define MC_ARRAY_PTR_BIT 29
`define MC_OBJECT_PTR_BIT 28
`define MC_INDEX_WIDTH_BIT 27
`define MC_STATIC_PTR_BIT 26
`define MC_ENABLE_BIT 0
`define MC_RESET 32'h0000_0000
`define MC_WRITE_MASK 32'hbc00_0001

// layout parameter fields
`define LP_BOUNDS_HI 21
`define LP_BOUNDS_LO 17
`define LP_DESC_SIGN_BIT 16
`define LP_DESC_HI 15
`define LP_DESC_LO 12
`define LP_ARRAY_DATA_HI 11
`define LP_ARRAY_DATA_LO 8
`define LP_STATIC_HI 7
`define LP_STATIC_LO 4
`define LP_FIELD_HI 3
`define LP_FIELD_LO 0
`define LP_RESET 32'h0000_0000
`define LP_WRITE_MASK 32'h003f_ffff

// opcode translation entry fields
`define OT_OPCODE_HI 15
`define OT_OPCODE_LO 10
`define OT_OPER_HI 3
`define OT_OPER_LO 0
`define OT_OPER_MAX 4'h9
`define OT_OPCODE_FIRST 8'hcb
`define OT_OPCODE_LAST 8'hfd
`define OT_OPCODE_BASE 8'hc0
`define OT_ENTRIES 64

`endif

/* design/opcode_translation_table.v */
/*
 table of configurable bytecode to hardware operation mappings.
 assumes writes are already qualified for privilege by the register bank.
*/
`timescale 1ns/1ps
`include "bytecode_accel_consts.vh"

module opcode_translation_table #(
  parameter ENTRIES = `OT_ENTRIES
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clear_all_i,
  input wire write_i,
  input wire [5:0] write_index_i,
  input wire [3:0] write_oper_i,
  input wire [7:0] lookup_opcode_i,
  output reg lookup_hit_o,
  output reg [3:0] lookup_oper_o
);

  reg [ENTRIES-1:0] valid_q;
  reg [3:0] oper_q [0:ENTRIES-1];
  wire [7:0] full_opcode;
  wire [5:0] lookup_index;
  wire in_range;

  assign full_opcode = `OT_OPCODE_BASE | {2'h0, write_index_i};
  assign lookup_index = lookup_opcode_i[5:0];
  assign in_range = (lookup_opcode_i >= `OT_OPCODE_FIRST) &&
                    (lookup_opcode_i <= `OT_OPCODE_LAST);

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1)
    begin : entry
      always @(posedge ref_clk_i)
      begin
        if (sys_rst_i || clear_all_i)
        begin
          valid_q[g] <= 1'b0;
          oper_q[g] <= 4'h0;
        end
        else if (write_i && (write_index_i == g) &&
                 (full_opcode >= `OT_OPCODE_FIRST) &&
                 (full_opcode <= `OT_OPCODE_LAST) &&
                 (write_oper_i <= `OT_OPER_MAX))
        begin
          valid_q[g] <= 1'b1;
          oper_q[g] <= write_oper_i;
        end
      end
    end
  endgenerate

  // registered lookup, unmapped opcodes go to software
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      lookup_hit_o <= 1'b0;
      lookup_oper_o <= 4'h0;
    end
    else
    begin
      lookup_hit_o <= in_range && valid_q[lookup_index];
      lookup_oper_o <= oper_q[lookup_index];
    end
  end

endmodule // opcode_translation_table

/* design/bytecode_accel_config_regs.v */
/*
 configuration registers of the bytecode acceleration hardware, reached by
 coprocessor transfers, plus the state entry decision they steer.
 assumes one transfer per cycle from the core, privilege given by the core.
*/
`timescale 1ns/1ps
`include "bytecode_accel_consts.vh"

module bytecode_accel_config_regs #(
  parameter TABLE_ENTRIES = `OT_ENTRIES
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire cp_valid_i,
  input wire cp_write_i,
  input wire [3:0] cp_num_i,
  input wire [2:0] cp_opc1_i,
  input wire [3:0] cp_crn_i,
  input wire [3:0] cp_crm_i,
  input wire [2:0] cp_opc2_i,
  input wire cp_privileged_i,
  input wire [31:0] cp_wdata_i,
  input wire config_valid_flag_i,
  input wire branch_to_bytecode_i,
  input wire set_state_bit_i,
  input wire [7:0] lookup_opcode_i,
  output reg [31:0] cp_rdata_o,
  output reg cp_rvalid_o,
  output reg cp_undefined_o,
  output reg enter_bytecode_state_o,
  output reg branch_exchange_o,
  output reg disabled_exception_o,
  output reg config_invalid_exception_o,
  output reg set_config_valid_o,
  output wire accel_hw_enable_o,
  output wire array_ops_software_only_o,
  output wire float_bytecode_hw_o,
  output wire array_reference_pointer_mode_o,
  output wire object_reference_pointer_mode_o,
  output wire field_index_width_o,
  output wire static_reference_pointer_mode_o,
  output wire [4:0] bounds_bit_shift_o,
  output wire descriptor_offset_negative_o,
  output wire [3:0] descriptor_word_offset_o,
  output wire [3:0] array_data_offset_o,
  output wire [3:0] static_value_offset_o,
  output wire [3:0] field_offset_o,
  output wire lookup_hit_o,
  output wire [3:0] lookup_oper_o
);

  reg [31:0] main_config_q;
  reg [31:0] main_config_d;
  reg [31:0] layout_params_q;
  reg [31:0] layout_params_d;
  reg [31:0] rdata_d;
  reg undefined_d;

  wire is_ours;
  wire allowed;
  wire wr_main;
  wire wr_params;
  wire wr_trans;
  wire wr_identity;
  wire any_entry;

  // selector match for a register index
  function sel_match;
    input [3:0] crn;
    input [3:0] want;
    begin
      sel_match = (crn == want);
    end
  endfunction

  // transfers that name our coprocessor space
  assign is_ours = cp_valid_i && (cp_num_i == `CP_NUM) && (cp_opc1_i == `CP_OPC1) &&
                   (cp_crm_i == `CP_CRM) && (cp_opc2_i == `CP_OPC2);
  assign allowed = is_ours && cp_privileged_i;
  assign wr_main = allowed && cp_write_i && sel_match(cp_crn_i, `CRN_MAIN_CONFIG);
  assign wr_params = allowed && cp_write_i && sel_match(cp_crn_i, `CRN_LAYOUT_PARAMS);
  assign wr_trans = allowed && cp_write_i && sel_match(cp_crn_i, `CRN_OPCODE_TRANS);
  assign wr_identity = allowed && cp_write_i && sel_match(cp_crn_i, `CRN_IDENTITY);

  // write data next values
  always @*
  begin
    main_config_d = main_config_q;
    layout_params_d = layout_params_q;
    if (wr_main)
      main_config_d = cp_wdata_i & `MC_WRITE_MASK;
    if (wr_params)
      layout_params_d = cp_wdata_i & `LP_WRITE_MASK;
  end

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      main_config_q <= `MC_RESET;
      layout_params_q <= `LP_RESET;
    end
    else
    begin
      main_config_q <= main_config_d;
      layout_params_q <= layout_params_d;
    end
  end

  // read mux and refusal
  always @*
  begin
    rdata_d = 32'h0000_0000;
    undefined_d = 1'b0;
    if (is_ours)
    begin
      if (!cp_privileged_i)
      begin
        if (sel_match(cp_crn_i, `CRN_MAIN_CONFIG) ||
            sel_match(cp_crn_i, `CRN_LAYOUT_PARAMS) ||
            sel_match(cp_crn_i, `CRN_OPCODE_TRANS))
          undefined_d = 1'b1;
      end
      else if (!cp_write_i)
      begin
        case (cp_crn_i)
          `CRN_MAIN_CONFIG: rdata_d = main_config_q & `MC_WRITE_MASK;
          `CRN_LAYOUT_PARAMS: rdata_d = layout_params_q;
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      cp_rdata_o <= 32'h0000_0000;
      cp_rvalid_o <= 1'b0;
      cp_undefined_o <= 1'b0;
    end
    else
    begin
      cp_rdata_o <= rdata_d;
      cp_rvalid_o <= allowed && !cp_write_i &&
                     (sel_match(cp_crn_i, `CRN_MAIN_CONFIG) ||
                      sel_match(cp_crn_i, `CRN_LAYOUT_PARAMS));
      cp_undefined_o <= undefined_d;
    end
  end

  // mode outputs
  assign array_ops_software_only_o = main_config_q[`MC_ARRAY_SW_BIT];
  assign float_bytecode_hw_o = 1'b0;
  assign array_reference_pointer_mode_o = main_config_q[`MC_ARRAY_PTR_BIT];
  assign object_reference_pointer_mode_o = main_config_q[`MC_OBJECT_PTR_BIT];
  assign field_index_width_o = main_config_q[`MC_INDEX_WIDTH_BIT];
  assign static_reference_pointer_mode_o = main_config_q[`MC_STATIC_PTR_BIT];
  assign accel_hw_enable_o = main_config_q[`MC_ENABLE_BIT];

  // layout parameter fields
  assign bounds_bit_shift_o = layout_params_q[`LP_BOUNDS_HI:`LP_BOUNDS_LO];
  assign descriptor_offset_negative_o = layout_params_q[`LP_DESC_SIGN_BIT];
  assign descriptor_word_offset_o = layout_params_q[`LP_DESC_HI:`LP_DESC_LO];
  assign array_data_offset_o = layout_params_q[`LP_ARRAY_DATA_HI:`LP_ARRAY_DATA_LO];
  assign static_value_offset_o = layout_params_q[`LP_STATIC_HI:`LP_STATIC_LO];
  assign field_offset_o = layout_params_q[`LP_FIELD_HI:`LP_FIELD_LO];

  // state entry decision
  assign any_entry = branch_to_bytecode_i || set_state_bit_i;

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      enter_bytecode_state_o <= 1'b0;
      branch_exchange_o <= 1'b0;
      disabled_exception_o <= 1'b0;
      config_invalid_exception_o <= 1'b0;
      set_config_valid_o <= 1'b0;
    end
    else
    begin
      enter_bytecode_state_o <= accel_hw_enable_o && config_valid_flag_i &&
                                any_entry;
      branch_exchange_o <= !accel_hw_enable_o && branch_to_bytecode_i;
      disabled_exception_o <= !accel_hw_enable_o && set_state_bit_i;
      config_invalid_exception_o <= accel_hw_enable_o && !config_valid_flag_i &&
                                    any_entry;
      set_config_valid_o <= accel_hw_enable_o && !config_valid_flag_i &&
                            any_entry;
    end
  end

  // entry fields placed by software
  opcode_translation_table #(
    .ENTRIES(TABLE_ENTRIES)
  ) trans_table (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_all_i(wr_identity),
    .write_i(wr_trans),
    .write_index_i(cp_wdata_i[`OT_OPCODE_HI:`OT_OPCODE_LO]),
    .write_oper_i(cp_wdata_i[`OT_OPER_HI:`OT_OPER_LO]),
    .lookup_opcode_i(lookup_opcode_i),
    .lookup_hit_o(lookup_hit_o),
    .lookup_oper_o(lookup_oper_o)
  );

endmodule // bytecode_accel_config_regs

/* verification/bytecode_accel_config_checker.sv */
/*
 checker for the bytecode acceleration configuration registers.
 assumes it is bound onto the register bank; one clock, sync reset.
*/
`timescale 1ns/1ps
module bytecode_accel_config_checker (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire cp_valid_i,
  input wire cp_write_i,
  input wire [3:0] cp_num_i,
  input wire [2:0] cp_opc1_i,
  input wire [3:0] cp_crn_i,
  input wire [3:0] cp_crm_i,
  input wire [2:0] cp_opc2_i,
  input wire cp_privileged_i,
  input wire [31:0] cp_wdata_i,
  input wire config_valid_flag_i,
  input wire branch_to_bytecode_i,
  input wire set_state_bit_i,
  input wire [31:0] cp_rdata_o,
  input wire cp_rvalid_o,
  input wire cp_undefined_o,
  input wire enter_bytecode_state_o,
  input wire branch_exchange_o,
  input wire disabled_exception_o,
  input wire config_invalid_exception_o,
  input wire set_config_valid_o,
  input wire accel_hw_enable_o,
  input wire float_bytecode_hw_o
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_req;
    cp_valid_i && cp_num_i == 4'he && cp_opc1_i == 3'h7 && cp_crm_i == 4'h0
      && cp_opc2_i == 3'h0 && cp_crn_i >= 4'h2 && cp_crn_i <= 4'h4;
  endsequence
  sequence s_go;
    accel_hw_enable_o && (branch_to_bytecode_i || set_state_bit_i);
  endsequence
  AST_USER_UNDEF: assert property (s_req ##0 !cp_privileged_i |=>
    cp_undefined_o && !cp_rvalid_o) else $error("user access not refused");
  AST_PRIV_OK: assert property (s_req ##0 cp_privileged_i |=> !cp_undefined_o)
    else $error("privileged access refused");
  AST_READ_ANS: assert property (s_req ##0 (cp_privileged_i && !cp_write_i &&
    cp_crn_i != 4'h4) |=> cp_rvalid_o) else $error("read not answered");
  AST_IDLE_RDATA: assert property (!cp_rvalid_o |-> cp_rdata_o == 32'h0)
    else $error("read data without answer");
  AST_FLOAT_ZERO: assert property (!float_bytecode_hw_o && !(cp_rvalid_o &&
    cp_rdata_o[30])) else $error("float bit set");
  AST_EN_WRITE: assert property (s_req ##0 (cp_privileged_i && cp_write_i &&
    cp_crn_i == 4'h2) |=> accel_hw_enable_o == $past(cp_wdata_i[0]))
    else $error("enable not written");
  AST_OFF_BRANCH: assert property (!accel_hw_enable_o && branch_to_bytecode_i |=>
    branch_exchange_o && !enter_bytecode_state_o) else $error("plain branch missing");
  AST_OFF_SET: assert property (!accel_hw_enable_o && set_state_bit_i |=>
    disabled_exception_o) else $error("disabled exception missing");
  AST_ENTER: assert property (s_go ##0 config_valid_flag_i |=>
    enter_bytecode_state_o && !config_invalid_exception_o) else $error("no state entry");
  AST_INVALID: assert property (s_go ##0 !config_valid_flag_i |=>
    config_invalid_exception_o && set_config_valid_o) else $error("no invalid exception");
  AST_RESET_OFF: assert property ($fell(sys_rst_i) |-> !accel_hw_enable_o)
    else $error("enabled after reset");
endmodule // bytecode_accel_config_checker

bind bytecode_accel_config_regs bytecode_accel_config_checker chk_i (.*);

/* verification/tb_bytecode_accel_config_regs.sv */
/*
 self-checking bench for the bytecode acceleration configuration registers.
 assumes the design files are compiled first; checker bound separately.
*/
`timescale 1ns/1ps
module tb_bytecode_accel_config_regs;
  reg ref_clk_i = 0;
  reg sys_rst_i = 1;
  reg cp_valid_i = 0, cp_write_i = 0, cp_privileged_i = 0;
  reg [3:0] cp_num_i = 4'h0, cp_crn_i = 4'h0, cp_crm_i = 4'h0;
  reg [2:0] cp_opc1_i = 3'h7, cp_opc2_i = 3'h0;
  reg [31:0] cp_wdata_i = 32'h0;
  reg config_valid_flag_i = 0, branch_to_bytecode_i = 0, set_state_bit_i = 0;
  reg [7:0] lookup_opcode_i = 8'h0;
  wire [31:0] cp_rdata_o;
  wire cp_rvalid_o, cp_undefined_o, enter_bytecode_state_o, branch_exchange_o;
  wire disabled_exception_o, config_invalid_exception_o, set_config_valid_o;
  wire accel_hw_enable_o, array_ops_software_only_o, float_bytecode_hw_o;
  wire array_reference_pointer_mode_o, object_reference_pointer_mode_o;
  wire field_index_width_o, static_reference_pointer_mode_o, lookup_hit_o;
  wire descriptor_offset_negative_o;
  wire [4:0] bounds_bit_shift_o;
  wire [3:0] descriptor_word_offset_o, array_data_offset_o, static_value_offset_o;
  wire [3:0] field_offset_o, lookup_oper_o;
  reg [31:0] mc, lp, r;
  reg [4:0] ent [0:63];
  integer seed, i, n_errors, checks;

  bytecode_accel_config_regs uut (.*);

  always #2 ref_clk_i = ~ref_clk_i;

  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      checks = checks + 1;
      if (s !== e)
      begin
        n_errors = n_errors + 1;
        $display("Error %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  task cp(input w, input p, input [3:0] n, input [3:0] c, input [31:0] d);
    reg a;
    reg [31:0] rd;
    integer j;
    begin
      cp_valid_i = 1;
      cp_write_i = w;
      cp_privileged_i = p;
      cp_num_i = n;
      cp_crn_i = c;
      cp_wdata_i = d;
      a = n == 4'he && c >= 4'h2 && c <= 4'h4;
      rd = (a && p && !w) ? (c == 4'h2 ? mc : (c == 4'h3 ? lp : 32'h0)) : 32'h0;
      if (n == 4'he && p && w)
        case (c)
          4'h0: for (j = 0; j < 64; j = j + 1) ent[j] = 5'h0;
          4'h2: mc = d & 32'hbc00_0001;
          4'h3: lp = d & 32'h003f_ffff;
          4'h4: if (d[3:0] <= 4'h9 && d[15:10] >= 6'h0b && d[15:10] <= 6'h3d)
            ent[d[15:10]] = {1'b1, d[3:0]};
          default: ;
        endcase
      @(negedge ref_clk_i);
      chk("rvalid", a && p && !w && c != 4'h4, cp_rvalid_o);
      chk("undef", a && !p, cp_undefined_o);
      chk("rdata", rd, cp_rdata_o);
      chk("config", {mc[31:26], mc[0]}, {array_ops_software_only_o, float_bytecode_hw_o,
        array_reference_pointer_mode_o, object_reference_pointer_mode_o, field_index_width_o,
        static_reference_pointer_mode_o, accel_hw_enable_o});
      chk("params", lp[21:0], {bounds_bit_shift_o, descriptor_offset_negative_o,
        descriptor_word_offset_o, array_data_offset_o, static_value_offset_o,
        field_offset_o});
    end
  endtask

  task lk(input [7:0] opcode);
    reg h;
    begin
      cp_valid_i = 0;
      lookup_opcode_i = opcode;
      h = opcode >= 8'hcb && opcode <= 8'hfd && ent[opcode[5:0]][4];
      @(negedge ref_clk_i);
      chk("hit", h, lookup_hit_o);
      if (h)
        chk("oper", ent[opcode[5:0]][3:0], lookup_oper_o);
    end
  endtask

  task st(input b, input s, input f);
    begin
      branch_to_bytecode_i = b;
      set_state_bit_i = s;
      config_valid_flag_i = f;
      @(negedge ref_clk_i);
      branch_to_bytecode_i = 0;
      set_state_bit_i = 0;
      chk("branch_exchange", !mc[0] && b, branch_exchange_o);
      chk("disexc", !mc[0] && s, disabled_exception_o);
      chk("enter", mc[0] && f && (b || s), enter_bytecode_state_o);
      chk("invalid", {2{mc[0] && !f && (b || s)}},
        {config_invalid_exception_o, set_config_valid_o});
      @(negedge ref_clk_i);
    end
  endtask

  task results;
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial
  begin
    seed = 32'h7e72;
    n_errors = 0;
    checks = 0;
    mc = 0;
    lp = 0;
    for (i = 0; i < 64; i = i + 1) ent[i] = 5'h0;
    repeat (8) @(negedge ref_clk_i);
    sys_rst_i = 0;
    cp(0, 1, 4'he, 4'h2, 0);
    cp(0, 1, 4'he, 4'h3, 0);
    cp(0, 1, 4'he, 4'h4, 0);
    lk(8'hcb);
    cp(1, 1, 4'he, 4'h4, 32'h0000_2c05);
    lk(8'hcb);
    cp(1, 1, 4'he, 4'h4, 32'h0000_2c0a);
    lk(8'hcb);
    cp(1, 0, 4'he, 4'h4, 32'h0000_3007);
    lk(8'hcc);
    cp(1, 1, 4'he, 4'h0, 0);
    lk(8'hcb);
    for (i = 0; i < 400; i = i + 1)
    begin
      r = $random(seed);
      cp(r[0] | r[1], r[2] | r[3] | r[4], r[7:5] == 3'h0 ? 4'hd : 4'he,
        {1'b0, r[10:8]} % 4'h5, $random(seed));
      lk({2'b11, cp_wdata_i[15:10]});
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      cp(1, 1, 4'he, 4'h2, i / 4);
      lk(8'hc0);
      st(i[1], !i[1], i[0]);
    end
    results;
  end
endmodule // tb_bytecode_accel_config_regs
